/* include/rir_defines.svh */
// Offsets, field positions and timing counts of the receive information registers
`ifndef RIR_DEFINES_SVH
`define RIR_DEFINES_SVH

// Register offsets on the parallel control port
`define RIR_OFS_LEVEL_CLOCK 8'h10
`define RIR_OFS_FRAMING 8'h22
`define RIR_OFS_ALARM_CLEAR 8'h31
`define RIR_RESET_VALUE 8'h00

// Framing information register fields
`define RIR_ALIGN_CHANGE_BIT 7
`define RIR_EIGHT_ZERO_BIT 6
`define RIR_SIXTEEN_ZERO_BIT 5
`define RIR_RX_FULL_BIT 4
`define RIR_RX_EMPTY_BIT 3
`define RIR_SEVERE_FRAMING_BIT 2
`define RIR_B8ZS_SEEN_BIT 1
`define RIR_FRAMING_ERR_BIT 0

// Alarm clear information register fields
`define RIR_SYNC_REGAINED_BIT 7
`define RIR_CARRIER_RESTORED_BIT 6
`define RIR_TX_FULL_BIT 5
`define RIR_TX_EMPTY_BIT 4
`define RIR_TX_SLIP_BIT 3
`define RIR_BLUE_CLEARED_BIT 2
`define RIR_RX_DENSITY_BIT 1
`define RIR_TX_DENSITY_BIT 0

// Level and clock information register fields
`define RIR_LEVEL_MSB_BIT 7
`define RIR_LEVEL_LSB_BIT 6
`define RIR_JITTER_LIMIT_BIT 5
`define RIR_CLOCK_LOST_BIT 4
`define RIR_CARRIER_LOST_BIT 3

// Line detector thresholds
`define RIR_EIGHT_ZERO_RUN 8
`define RIR_SIXTEEN_ZERO_RUN 16
`define RIR_CARRIER_ZERO_RUN 192
`define RIR_RESTORE_WINDOW 7'd112
`define RIR_RESTORE_ONES 4'd14
`define RIR_SEVERE_ERR_COUNT 2
`define RIR_JITTER_MARGIN 8'd4

// Receive clock loss timing
`define RIR_SYS_CLK_NS 50
`define RIR_CLK_LOSS_MIN_NS 2000
`define RIR_CLK_LOSS_MAX_NS 4000
`define RIR_CLK_LOSS_CYC ((`RIR_CLK_LOSS_MIN_NS + `RIR_SYS_CLK_NS - 1) / `RIR_SYS_CLK_NS)

`endif

/* include/rir_pkg.sv */
// Types shared by the receive information status logic
package rir_pkg;

  // Carrier loss and restore tracking
  typedef enum logic [1:0] {
    RIR_CARRIER_OK,
    RIR_CARRIER_LOST,
    RIR_CARRIER_WINDOW
  } rir_carrier_t;

  // One-cycle event pulses from framer and elastic stores
  typedef struct packed {
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
    logic tx_slip;
    logic fbit_valid;
    logic fbit_err;
    logic b8zs_seen;
    logic resync_done;
  } rir_frm_ev_t;

  // Alarm levels from framer and line interface
  typedef struct packed {
    logic in_sync;
    logic carrier_ok;
    logic blue_alarm;
  } rir_lvl_t;

endpackage

/* rtl/rir_zero_run.sv */
// Zero run detector pulsing once when a run reaches its threshold
`timescale 1ns/1ns
module rir_zero_run #(
  parameter int unsigned THRESH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bit stream
  input wire logic bit_valid,
  input wire logic bit_one,
  // Threshold reached
  output logic run_hit
);
  import rir_pkg::*;

  localparam logic [7:0] LIM = THRESH[7:0];

  logic [7:0] run_cnt;
  logic [7:0] next_run_cnt;
  logic next_run_hit;

  // Saturating count so one long run gives one pulse only
  always_comb begin
    next_run_cnt = run_cnt;
    next_run_hit = 1'b0;
    if (bit_valid) begin
      if (bit_one) begin
        next_run_cnt = 8'h00;
      end else if (run_cnt != LIM) begin
        next_run_cnt = run_cnt + 8'h01;
        next_run_hit = (run_cnt == LIM - 8'h01);
      end
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_cnt <= 8'h00;
      run_hit <= 1'b0;
    end else begin
      run_cnt <= next_run_cnt;
      run_hit <= next_run_hit;
    end
  end

  // Pulse only when the run reaches its threshold
  hit_on_threshold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run_hit |-> run_cnt == LIM && $past(bit_valid) && !$past(bit_one))
    else $error("zero run pulse without threshold");

  // Counter never passes threshold
  count_saturates_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run_cnt <= LIM)
    else $error("zero run counter passed threshold");

endmodule

/* rtl/rir_status.sv */
// Receive information registers: line detectors, latched flags, masked host reads
// Functional notes
// - Flag runs of sixteen or more zeros
// - Flag elastic store full, frame deleted
// - Flag elastic store empty, frame repeated
// - Flag transmit store slip, repeat or delete
// - Flag carrier restore, hold until read
// - Flag blue alarm end, hold until read
// - Flag ones density failure, both directions
// - Flag jitter fill within four of limit
// - Flag receive clock idle two to four us
// - Carrier loss after 192 consecutive zeros
// - Carrier loss clears on 14 ones/112
// - Receive level in level register bits 7:6
// - Level register bits 2:0 carry nothing
// - Level code 00 to 11, rising attenuation
// - Latch events, clear on read, reset again
// - Written mask selects which copy bits update
`timescale 1ns/1ns
`include "rir_defines.svh"
module rir_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Receive line pins
  input wire logic rx_clock_in,
  input wire logic rx_positive_rail_in,
  input wire logic rx_negative_rail_in,
  // Transmit bit stream after formatter
  input wire logic tx_bit_valid,
  input wire logic tx_bit_one,
  // Framer, elastic store and line interface status
  input wire rir_pkg::rir_frm_ev_t frm_ev,
  input wire logic [7:0] align_pos,
  input wire rir_pkg::rir_lvl_t lvl,
  input wire logic [6:0] ja_fill,
  input wire logic [6:0] ja_limit,
  input wire logic [1:0] rx_level,
  // Parallel control port
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata
);
  import rir_pkg::*;

  localparam logic [6:0] LOSS_CYC = 7'(`RIR_CLK_LOSS_CYC);

  // Line input synchronisers and recovered bit strobe
  logic rck_s1, rck_s2, rck_s3, pos_s1, pos_s2, neg_s1, neg_s2;
  logic [6:0] idle_cnt;
  logic [6:0] next_idle_cnt;
  logic rx_bit_valid, rx_bit_one, clk_lost;

  assign rx_bit_valid = rck_s2 & ~rck_s3;
  assign rx_bit_one = pos_s2 | neg_s2;
  assign clk_lost = (idle_cnt == LOSS_CYC);

  always_comb begin
    next_idle_cnt = idle_cnt;
    if (rck_s2 != rck_s3) begin
      next_idle_cnt = 7'h00;
    end else if (!clk_lost) begin
      next_idle_cnt = idle_cnt + 7'h01;
    end
  end

  // Two stages before any logic reads a pin
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rck_s1 <= 1'b0;
      rck_s2 <= 1'b0;
      rck_s3 <= 1'b0;
      pos_s1 <= 1'b0;
      pos_s2 <= 1'b0;
      neg_s1 <= 1'b0;
      neg_s2 <= 1'b0;
      idle_cnt <= 7'h00;
    end else begin
      rck_s1 <= rx_clock_in;
      rck_s2 <= rck_s1;
      rck_s3 <= rck_s2;
      pos_s1 <= rx_positive_rail_in;
      pos_s2 <= pos_s1;
      neg_s1 <= rx_negative_rail_in;
      neg_s2 <= neg_s1;
      idle_cnt <= next_idle_cnt;
    end
  end

  // Zero run detectors on receive and transmit streams
  logic zero8_hit, zero16_hit, zero192_hit, tx_zero16_hit;

  rir_zero_run #(.THRESH(`RIR_EIGHT_ZERO_RUN)) u_zero8 (
    .sys_clk(sys_clk), .reset_n(reset_n), .bit_valid(rx_bit_valid),
    .bit_one(rx_bit_one), .run_hit(zero8_hit));
  rir_zero_run #(.THRESH(`RIR_SIXTEEN_ZERO_RUN)) u_zero16 (
    .sys_clk(sys_clk), .reset_n(reset_n), .bit_valid(rx_bit_valid),
    .bit_one(rx_bit_one), .run_hit(zero16_hit));
  rir_zero_run #(.THRESH(`RIR_CARRIER_ZERO_RUN)) u_zero192 (
    .sys_clk(sys_clk), .reset_n(reset_n), .bit_valid(rx_bit_valid),
    .bit_one(rx_bit_one), .run_hit(zero192_hit));
  rir_zero_run #(.THRESH(`RIR_SIXTEEN_ZERO_RUN)) u_tx_zero16 (
    .sys_clk(sys_clk), .reset_n(reset_n), .bit_valid(tx_bit_valid),
    .bit_one(tx_bit_one), .run_hit(tx_zero16_hit));

  // Framer carrier loss tracking
  rir_carrier_t carrier_state, next_carrier_state;
  logic [6:0] win_cnt, next_win_cnt;
  logic [3:0] ones_cnt, next_ones_cnt;

  // entry on long zero run, exit on ones density window
  always_comb begin
    next_carrier_state = carrier_state;
    next_win_cnt = win_cnt;
    next_ones_cnt = ones_cnt;
    case (carrier_state)
      RIR_CARRIER_OK: begin
        if (zero192_hit) begin
          next_carrier_state = RIR_CARRIER_LOST;
        end
      end
      RIR_CARRIER_LOST: begin
        // Window opens on the first one received
        if (rx_bit_valid && rx_bit_one) begin
          next_carrier_state = RIR_CARRIER_WINDOW;
          next_win_cnt = 7'h01;
          next_ones_cnt = 4'h1;
        end
      end
      RIR_CARRIER_WINDOW: begin
        if (rx_bit_valid) begin
          next_win_cnt = win_cnt + 7'h01;
          next_ones_cnt = ones_cnt + {3'h0, rx_bit_one};
          if (next_ones_cnt >= `RIR_RESTORE_ONES) begin
            next_carrier_state = RIR_CARRIER_OK;
          end else if (next_win_cnt == `RIR_RESTORE_WINDOW) begin
            next_carrier_state = RIR_CARRIER_LOST;
          end
        end
      end
      default: begin
        next_carrier_state = RIR_CARRIER_OK;
      end
    endcase
  end

  // Carrier state registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_state <= RIR_CARRIER_OK;
      win_cnt <= 7'h00;
      ones_cnt <= 4'h0;
    end else begin
      carrier_state <= next_carrier_state;
      win_cnt <= next_win_cnt;
      ones_cnt <= next_ones_cnt;
    end
  end

  // Framing error history, alignment memory and alarm edges
  logic [5:0] ferr_hist, next_ferr_hist;
  logic [7:0] prev_align, next_prev_align;
  rir_lvl_t lvl_q;
  logic severe_hit, align_moved, ja_near;

  assign severe_hit = frm_ev.fbit_valid && ($countones(next_ferr_hist) >= `RIR_SEVERE_ERR_COUNT);
  assign align_moved = frm_ev.resync_done && (align_pos != prev_align);
  // extended to eight bits so the margin cannot wrap
  assign ja_near = ({1'b0, ja_fill} + `RIR_JITTER_MARGIN) >= {1'b0, ja_limit};

  always_comb begin
    next_ferr_hist = ferr_hist;
    next_prev_align = prev_align;
    if (frm_ev.fbit_valid) begin
      next_ferr_hist = {ferr_hist[4:0], frm_ev.fbit_err};
    end
    if (frm_ev.resync_done) begin
      next_prev_align = align_pos;
    end
  end

  // History registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ferr_hist <= 6'h00;
      prev_align <= 8'h00;
      lvl_q <= '0;
    end else begin
      ferr_hist <= next_ferr_hist;
      prev_align <= next_prev_align;
      lvl_q <= lvl;
    end
  end

  // Set vectors, one per register
  logic [7:0] set1, set2, set3;

  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    set3 = 8'h00;
    set1[`RIR_ALIGN_CHANGE_BIT] = align_moved;
    set1[`RIR_EIGHT_ZERO_BIT] = zero8_hit;
    set1[`RIR_SIXTEEN_ZERO_BIT] = zero16_hit;
    set1[`RIR_RX_FULL_BIT] = frm_ev.rx_full;
    set1[`RIR_RX_EMPTY_BIT] = frm_ev.rx_empty;
    set1[`RIR_SEVERE_FRAMING_BIT] = severe_hit;
    set1[`RIR_B8ZS_SEEN_BIT] = frm_ev.b8zs_seen;
    set1[`RIR_FRAMING_ERR_BIT] = frm_ev.fbit_valid & frm_ev.fbit_err;
    set2[`RIR_SYNC_REGAINED_BIT] = lvl.in_sync & ~lvl_q.in_sync;
    set2[`RIR_CARRIER_RESTORED_BIT] = lvl.carrier_ok & ~lvl_q.carrier_ok;
    set2[`RIR_TX_FULL_BIT] = frm_ev.tx_full;
    set2[`RIR_TX_EMPTY_BIT] = frm_ev.tx_empty;
    set2[`RIR_TX_SLIP_BIT] = frm_ev.tx_slip;
    set2[`RIR_BLUE_CLEARED_BIT] = ~lvl.blue_alarm & lvl_q.blue_alarm;
    set2[`RIR_RX_DENSITY_BIT] = zero16_hit;
    set2[`RIR_TX_DENSITY_BIT] = tx_zero16_hit;
    set3[`RIR_JITTER_LIMIT_BIT] = ja_near;
    set3[`RIR_CLOCK_LOST_BIT] = clk_lost;
    set3[`RIR_CARRIER_LOST_BIT] = (carrier_state != RIR_CARRIER_OK);
  end

  // Latched flags, host copies and read data
  logic [7:0] lat1, lat2, lat3, copy1, copy2, copy3;
  logic [7:0] next_lat1, next_lat2, next_lat3;
  logic [7:0] next_copy1, next_copy2, next_copy3, next_rdata;
  logic [7:0] live3;
  logic rd1, rd2, rd3, wr1, wr2, wr3;

  assign rd1 = bus_rd && (bus_addr == `RIR_OFS_FRAMING);
  assign rd2 = bus_rd && (bus_addr == `RIR_OFS_ALARM_CLEAR);
  assign rd3 = bus_rd && (bus_addr == `RIR_OFS_LEVEL_CLOCK);
  assign wr1 = bus_wr && (bus_addr == `RIR_OFS_FRAMING);
  assign wr2 = bus_wr && (bus_addr == `RIR_OFS_ALARM_CLEAR);
  assign wr3 = bus_wr && (bus_addr == `RIR_OFS_LEVEL_CLOCK);
  // level is live, low bits read zero
  assign live3 = {rx_level, lat3[5:3], 3'h0};

  always_comb begin
    // clear what was shown on read, a same-cycle set wins
    next_lat1 = (lat1 & ~(rd1 ? copy1 : 8'h00)) | set1;
    next_lat2 = (lat2 & ~(rd2 ? copy2 : 8'h00)) | set2;
    next_lat3 = ((lat3 & ~(rd3 ? copy3 : 8'h00)) | set3) & 8'h38;
    // mask write refreshes only ones, write-back leaves late arrivals latched
    next_copy1 = wr1 ? ((bus_wdata & lat1) | (~bus_wdata & copy1)) : copy1;
    next_copy2 = wr2 ? ((bus_wdata & lat2) | (~bus_wdata & copy2)) : copy2;
    next_copy3 = wr3 ? ((bus_wdata & live3) | (~bus_wdata & copy3)) : copy3;
    // Unmapped reads answer zero
    next_rdata = bus_rdata;
    if (bus_rd) begin
      next_rdata = rd1 ? copy1 : rd2 ? copy2 : rd3 ? copy3 : 8'h00;
    end
  end

  // Register stage for flags and port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lat1 <= `RIR_RESET_VALUE;
      lat2 <= `RIR_RESET_VALUE;
      lat3 <= `RIR_RESET_VALUE;
      copy1 <= `RIR_RESET_VALUE;
      copy2 <= `RIR_RESET_VALUE;
      copy3 <= `RIR_RESET_VALUE;
      bus_rdata <= `RIR_RESET_VALUE;
    end else begin
      lat1 <= next_lat1;
      lat2 <= next_lat2;
      lat3 <= next_lat3;
      copy1 <= next_copy1;
      copy2 <= next_copy2;
      copy3 <= next_copy3;
      bus_rdata <= next_rdata;
    end
  end

  // Clock loss flag within the bound
  clock_loss_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(clk_lost) |=> lat3[`RIR_CLOCK_LOST_BIT])
    else $error("clock loss not latched");

  // No clock loss within eight cycles after a clock edge
  clock_idle_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rck_s2 != rck_s3) |=> !clk_lost [*8])
    else $error("clock loss raised too early");

  // Set beats same-cycle read clear
  set_beats_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (|set2) |=> ((lat2 & $past(set2)) == $past(set2)))
    else $error("event lost against clear");

  // Read clears reported bits
  read_clears_bits_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd1 && set1 == 8'h00) |=> ((lat1 & $past(copy1)) == 8'h00))
    else $error("reported flag not cleared");

  // Mask write merges latest and held bits
  mask_write_merge_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr2 |=> copy2 == (($past(bus_wdata) & $past(lat2)) | (~$past(bus_wdata) & $past(copy2))))
    else $error("mask write merge wrong");

  // Spare level bits read zero
  spare_bits_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rd3 |=> bus_rdata[2:0] == 3'h0)
    else $error("spare bits not zero");

  // Carrier loss flag held while not restored
  carrier_loss_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (carrier_state != RIR_CARRIER_OK) |=> lat3[`RIR_CARRIER_LOST_BIT])
    else $error("carrier loss flag dropped");

  // Restore window never passes its length
  restore_window_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (carrier_state == RIR_CARRIER_WINDOW) |-> win_cnt < `RIR_RESTORE_WINDOW)
    else $error("restore window overran");

  // Unmapped read answers zero
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (bus_rd && !rd1 && !rd2 && !rd3) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule

/* sim/rir_host.sv */
// Host model: masked write, read and write-back on the control port
`timescale 1ns/1ns
module rir_host (
  // Clock
  input wire logic sys_clk,
  // Control port
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  // Port idle from time zero
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // One strobe held across exactly one rising edge
  task automatic strobe(input logic [7:0] addr, input logic [7:0] data, input logic rd);
    @(negedge sys_clk);
    bus_addr = addr;
    bus_wdata = data;
    bus_wr = !rd;
    bus_rd = rd;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  endtask

  // mask, read, write back
  // Write-back clears only what was shown, so late events survive
  task automatic poll(input logic [7:0] addr, input logic [7:0] mask, output logic [7:0] data);
    strobe(addr, mask, 1'b0);
    strobe(addr, 8'h00, 1'b1);
    @(negedge sys_clk);
    data = bus_rdata;
    strobe(addr, data & mask, 1'b0);
  endtask
endmodule

/* sim/tb_top.sv */
// Testbench for the receive information status registers
`timescale 1ns/1ns
module tb_top;
  import rir_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_clock_in = 1'b0;
  logic rx_positive_rail_in = 1'b0;
  logic rx_negative_rail_in = 1'b0;
  logic tx_bit_valid = 1'b0;
  logic tx_bit_one = 1'b0;
  rir_frm_ev_t frm_ev = '0;
  logic [7:0] align_pos = 8'h05;
  rir_lvl_t lvl = '0;
  logic [6:0] ja_fill = 7'h00;
  logic [6:0] ja_limit = 7'h7f;
  logic [1:0] rx_level = 2'h0;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  logic [7:0] d;
  int fail_count = 0;
  int checked = 0;
  logic [8:0] ev_tab [6] = '{9'h001, 9'h001, 9'h100, 9'h080, 9'h00c, 9'h00c};
  logic [7:0] adr_tab [6] = '{8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22};
  logic [7:0] exp_tab [6] = '{8'h80, 8'h00, 8'h10, 8'h08, 8'h01, 8'h05};

  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;

  rir_status u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .rx_clock_in(rx_clock_in),
    .rx_positive_rail_in(rx_positive_rail_in), .rx_negative_rail_in(rx_negative_rail_in),
    .tx_bit_valid(tx_bit_valid), .tx_bit_one(tx_bit_one), .frm_ev(frm_ev),
    .align_pos(align_pos), .lvl(lvl), .ja_fill(ja_fill), .ja_limit(ja_limit),
    .rx_level(rx_level), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata)
  );

  rir_host u_host (
    .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata)
  );

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Line bits, four system clocks each; line clock then stands still high
  task automatic rx_bits(input int n, input logic one);
    repeat (n) begin
      @(negedge sys_clk);
      rx_positive_rail_in = one;
      rx_clock_in = 1'b0;
      repeat (2) @(negedge sys_clk);
      rx_clock_in = 1'b1;
      @(negedge sys_clk);
    end
    repeat (8) @(negedge sys_clk);
  endtask

  // One-cycle framer event pulse
  task automatic ev_pulse(input logic [8:0] v);
    @(negedge sys_clk);
    frm_ev = rir_frm_ev_t'(v);
    @(negedge sys_clk);
    frm_ev = '0;
  endtask

  // Nothing latched after reset, unmapped place reads zero
  task automatic t_reset;
    u_host.poll(8'h22, 8'hff, d);
    check(d, 8'h00);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h00);
    u_host.poll(8'h55, 8'hff, d);
    check(d, 8'h00);
  endtask

  // Zero runs, carrier loss and restore, receive clock loss
  task automatic t_line;
    rx_bits(192, 1'b0);
    repeat (60) @(negedge sys_clk);
    u_host.poll(8'h10, 8'h38, d);
    check(d & 8'hf8, 8'h18);
    u_host.poll(8'h22, 8'hff, d);
    check(d, 8'h60);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h02);
    rx_bits(14, 1'b1);
    u_host.poll(8'h10, 8'h18, d);
    u_host.poll(8'h10, 8'h18, d);
    check(d & 8'hf8, 8'h00);
    u_host.poll(8'h22, 8'hff, d);
    check(d, 8'h00);
    repeat (85) @(negedge sys_clk);
    u_host.poll(8'h10, 8'h10, d);
    check(d, 8'h10);
  endtask

  // Framer and store events; resync entries first so the severe flag is last
  task automatic t_events;
    for (int i = 0; i < 6; i++) begin
      ev_pulse(ev_tab[i]);
      u_host.poll(adr_tab[i], 8'hff, d);
      check(d, exp_tab[i]);
    end
    ev_pulse(9'h040);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h20);
    ev_pulse(9'h020);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h10);
    ev_pulse(9'h010);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h08);
    // A zero mask keeps the old copy and leaves the event latched
    ev_pulse(9'h040);
    u_host.poll(8'h31, 8'h00, d);
    check(d, 8'h00);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h20);
  endtask

  // Alarm edges held until read, transmit density failure
  task automatic t_alarms;
    @(negedge sys_clk);
    lvl = 3'b111;
    repeat (20) @(negedge sys_clk);
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'hc0);
    lvl = 3'b110;
    repeat (16) begin
      @(negedge sys_clk);
      tx_bit_valid = 1'b1;
      @(negedge sys_clk);
      tx_bit_valid = 1'b0;
    end
    u_host.poll(8'h31, 8'hff, d);
    check(d, 8'h05);
  endtask

  // Level codes and jitter margin boundary
  task automatic t_levels;
    for (int i = 0; i < 4; i++) begin
      rx_level = 2'(i);
      // Clock loss bit stays as the last 0x10 write-back left it, the level mask leaves it alone
      u_host.poll(8'h10, 8'hc0, d);
      check(d & 8'hf8, {2'(i), 6'h10});
    end
    ja_limit = 7'd64;
    ja_fill = 7'd60;
    // Level code 3 and clock loss are held copy bits, only the jitter bit is refreshed
    u_host.poll(8'h10, 8'h20, d);
    check(d, 8'hf0);
    ja_fill = 7'd59;
    u_host.poll(8'h10, 8'h20, d);
    u_host.poll(8'h10, 8'h20, d);
    check(d, 8'hd0);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end

  // Reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_line();
    t_events();
    t_alarms();
    t_levels();
    test_done();
  end
endmodule
